// ---- bench/head_sweep_cycle_controller_tb.sv ----
/*
 * self-checking bench for the sweep cycle controller: expected moves
 * are queued by the stimulus and popped by a monitor on each move.
 * assumes short minute and period parameters, positioner model below.
 */
`timescale 1ns/1ps
module head_sweep_cycle_controller_tb;
    import sweep_pkg::*;

    localparam int unsigned MC    = 10;
    localparam int unsigned PM    = 15;
    localparam int unsigned ST    = 8;
    localparam int          LIMIT = 6000;

    logic             mclk, rst_b, clk_en, selected, drive_busy, seek_done;
    logic             move_req, sweep_active, seek_ack;
    straps_t          straps_pin;
    seek_req_t        tag1_seek;
    logic [CYL_W-1:0] move_cyl, cur, home;
    logic [CYL_W-1:0] expq[$];
    logic [31:0]      rng;
    int               errors, checks_done, cycles, rst_at, n;

    head_sweep_cycle_controller #(
        .MINUTE_CYC(MC),
        .PERIOD_MIN(PM),
        .STEPS(ST)
    ) head_sweep_cycle_controller_inst (
        .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
        .straps_pin(straps_pin), .selected(selected),
        .tag1_seek(tag1_seek), .drive_busy(drive_busy),
        .seek_done(seek_done), .move_req(move_req),
        .move_cyl(move_cyl), .sweep_active(sweep_active),
        .seek_ack(seek_ack)
    );

    positioner_model positioner_model_inst (
        .mclk(mclk), .move_req(move_req), .seek_done(seek_done)
    );

    always #10 mclk = ~mclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [CYL_W-1:0] seen,
                         input logic [CYL_W-1:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic do_reset(input straps_t s);
        straps_pin = s;
        rst_b = 1'b0;
        tick(3);
        rst_b = 1'b1;
        cur = CYL_RESET;
        // straps need two edges through the synchroniser
        tick(2);
        rst_at = cycles;
    endtask

    task automatic push_sweep();
        for (int k = 0; k < ST; k++)
        begin
            cur = cur + SWEEP_STRIDE;
            expq.push_back(cur);
        end
    endtask

    task automatic drain(input int lim);
        int w;
        w = 0;
        while (expq.size() != 0 && w < lim)
        begin
            tick(1);
            w++;
        end
        check("moves left", CYL_W'(expq.size()), 12'h000);
    endtask

    task automatic seek(input logic sweep_first);
        logic [CYL_W-1:0] c;
        int               w;
        rng = xs(rng);
        c = rng[CYL_W-1:0];
        if (sweep_first)
            push_sweep();
        expq.push_back(c);
        cur = c;
        selected = 1'b1;
        tag1_seek = '{valid: 1'b1, cyl: c};
        tick(1);
        tag1_seek.valid = 1'b0;
        w = 0;
        while (seek_ack !== 1'b1 && w < 400)
        begin
            tick(1);
            w++;
        end
        check("seek_ack", {11'h000, seek_ack}, 12'h001);
        check("moves left", CYL_W'(expq.size()), 12'h000);
        selected = 1'b0;
        // let an edge pass so a following seek does not re-raise select
        tick(1);
    endtask

    // every move must be one the stimulus announced, in order
    always @(posedge mclk)
    begin
        if (move_req === 1'b1)
        begin
            if (expq.size() == 0)
                check("unexpected move", 12'h001, 12'h000);
            else
                check("move_cyl", move_cyl, expq.pop_front());
        end
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            errors++;
            close_out();
        end
    end

    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        selected = 1'b0;
        drive_busy = 1'b0;
        clk_en = 1'b1;
        straps_pin = '0;
        tag1_seek = '0;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        rng = 32'h0000_004F;
        cur = CYL_RESET;
        // disabled, with return_after set and seek_only open: seeks stay direct
        do_reset(3'h5);
        seek(1'b0);
        tick(400);
        seek(1'b0);
        // autonomous, return open: busy holds the sweep off
        do_reset(3'h2);
        seek(1'b0);
        drive_busy = 1'b1;
        tick(250);
        drive_busy = 1'b0;
        push_sweep();
        drain(300);
        tick(40);
        // autonomous, return connected, selected recently
        do_reset(3'h3);
        tick(60);
        seek(1'b0);
        home = cur;
        push_sweep();
        expq.push_back(home);
        cur = home;
        n = 0;
        while (sweep_active !== 1'b1 && n < 400)
        begin
            tick(1);
            n++;
        end
        n = cycles - rst_at;
        check("sweep start", {11'h000, (n > 135 && n < 170)}, 12'h001);
        drain(400);
        // next sweep comes with no recent selection: no return
        push_sweep();
        drain(400);
        tick(40);
        // seek-only mode
        do_reset(3'h0);
        seek(1'b0);
        // a frozen stretch inside the wait: nothing may move meanwhile
        clk_en = 1'b0;
        tick(100);
        clk_en = 1'b1;
        tick(300);
        seek(1'b1);
        seek(1'b0);
        close_out();
    end
endmodule

// ---- bench/positioner_model.sv ----
/*
 * head positioner stand-in: answers every move pulse with a one-cycle
 * completion pulse, alternating a prompt and a slow answer.
 * assumes move_req is a registered one-cycle pulse on mclk.
 */
`timescale 1ns/1ps
module positioner_model
(
    input  wire logic mclk,      // drive clock
    input  wire logic move_req,  // move pulse from the block
    output logic      seek_done  // move finished pulse
);
    int unsigned n_moves;

    initial
    begin
        seek_done = 1'b0;
        n_moves = 0;
        forever
        begin
            @(posedge mclk);
            if (move_req === 1'b1)
            begin
                n_moves++;
                // slow answers widen the window where seeks could slip in
                repeat ((n_moves % 2 == 1) ? 1 : 6) @(posedge mclk);
                #1 seek_done = 1'b1;
                @(posedge mclk);
                #1 seek_done = 1'b0;
            end
        end
    end
endmodule

// ---- logic/head_sweep_cycle_controller.sv ----
/*
 * head sweep cycle controller: schedules sweep segments, merges
 * controller seeks, and drives the head positioner.
 * assumes a positioner that answers each move with seek_done, and
 * strap pins that are asynchronous to mclk.
 */
`timescale 1ns/1ps
module head_sweep_cycle_controller
    import sweep_pkg::*;
#(
    parameter int unsigned MINUTE_CYC = MINUTE_CYCLES,
    parameter int unsigned PERIOD_MIN = SWEEP_PERIOD_MIN,
    parameter int unsigned STEPS      = SWEEP_STEPS
)(
    input  wire logic             mclk,          // drive clock
    input  wire logic             rst_b,         // sync reset, low
    input  wire logic             clk_en,        // freezes state when low
    input  wire straps_t          straps_pin,    // raw strap levels
    input  wire logic             selected,      // controller select
    input  wire seek_req_t        tag1_seek,     // controller seek pulse
    input  wire logic             drive_busy,    // other drive activity
    input  wire logic             seek_done,     // positioner finished
    output logic                  move_req,      // positioner move pulse
    output logic [CYL_W-1:0]      move_cyl,      // target cylinder
    output logic                  sweep_active,  // sweep in progress
    output logic                  seek_ack       // controller seek done
);

    straps_t              strap_s1_q, strap_q;
    logic                 minute_tick;
    logic [31:0]          tick_cnt_q, tick_cnt_d;
    logic [MIN_W-1:0]     since_sel_q, since_sel_d;
    logic [MIN_W-1:0]     since_swp_q, since_swp_d;
    sweep_state_t         state_q, state_d;
    logic [3:0]           step_q, step_d;
    logic [CYL_W-1:0]     cur_cyl_q, cur_cyl_d;
    logic [CYL_W-1:0]     home_cyl_q, home_cyl_d;
    logic [CYL_W-1:0]     pend_cyl_q, pend_cyl_d;
    logic                 pend_q, pend_d;
    logic                 by_seek_q, by_seek_d;
    logic                 ret_ok_q, ret_ok_d;
    logic                 move_req_d, sweep_active_d, seek_ack_d;
    logic [CYL_W-1:0]     move_cyl_d;
    logic                 enabled, seek_only, timer_run, due, recent_sel;

    // straps are pins: two flops before use
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            strap_s1_q <= '0;
            strap_q    <= '0;
        end
        else if (clk_en)
        begin
            strap_s1_q <= straps_pin;
            strap_q    <= strap_s1_q;
        end
    end

    assign enabled   = !strap_q.sweep_disable;
    assign seek_only = enabled && !strap_q.seek_only;
    assign timer_run = since_swp_q < MIN_W'(IDLE_WAIT_MIN);
    // a full thirteen hour period between autonomous sweeps keeps
    // the sweep duty well under one percent
    assign due       = since_swp_q >= MIN_W'(PERIOD_MIN);
    assign recent_sel = since_sel_q < MIN_W'(IDLE_WAIT_MIN);
    assign minute_tick = tick_cnt_q == 32'(MINUTE_CYC - 1);

    // minute time base and the two elapsed-minute counters
    always_comb
    begin
        tick_cnt_d  = minute_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        since_sel_d = since_sel_q;
        since_swp_d = since_swp_q;
        // saturate so the counters never wrap back to "recent"
        if (minute_tick && since_sel_q != '1)
            since_sel_d = since_sel_q + MIN_W'(1);
        if (minute_tick && since_swp_q != '1)
            since_swp_d = since_swp_q + MIN_W'(1);
        if (selected)
            since_sel_d = '0;
        if (state_q == ST_SWEEP_WAIT && seek_done && step_q == 4'(STEPS - 1))
            since_swp_d = '0;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            tick_cnt_q  <= 32'h0000_0000;
            since_sel_q <= '0;
            since_swp_q <= '0;
        end
        else if (clk_en)
        begin
            tick_cnt_q  <= tick_cnt_d;
            since_sel_q <= since_sel_d;
            since_swp_q <= since_swp_d;
        end
    end

    // sweep sequencer
    always_comb
    begin
        state_d        = state_q;
        step_d         = step_q;
        cur_cyl_d      = cur_cyl_q;
        home_cyl_d     = home_cyl_q;
        pend_cyl_d     = pend_cyl_q;
        pend_d         = pend_q;
        by_seek_d      = by_seek_q;
        ret_ok_d       = ret_ok_q;
        move_req_d     = 1'b0;
        move_cyl_d     = move_cyl;
        seek_ack_d     = 1'b0;
        sweep_active_d = sweep_active;
        // a seek arriving mid-sweep is held until the sweep ends
        if (tag1_seek.valid && state_q != ST_IDLE)
        begin
            pend_d     = 1'b1;
            pend_cyl_d = tag1_seek.cyl;
        end
        unique case (state_q)
            ST_IDLE:
            begin
                sweep_active_d = 1'b0;
                if (tag1_seek.valid || pend_q)
                begin
                    pend_cyl_d = tag1_seek.valid ? tag1_seek.cyl : pend_cyl_q;
                    pend_d     = 1'b1;
                    if (seek_only && !timer_run)
                    begin
                        by_seek_d = 1'b1;
                        home_cyl_d = cur_cyl_q;
                        step_d    = '0;
                        state_d   = ST_SWEEP_MOVE;
                    end
                    else
                    begin
                        // timer running, autonomous mode or sweeps disabled: no sweep
                        pend_d     = 1'b0;
                        move_req_d = 1'b1;
                        move_cyl_d = pend_cyl_d;
                        cur_cyl_d  = pend_cyl_d;
                        by_seek_d  = 1'b1;
                        state_d    = ST_FINAL_WAIT;
                    end
                end
                else if (enabled && !seek_only && due && !drive_busy
                         && !selected)
                begin
                    by_seek_d  = 1'b0;
                    // look back from the sweep start, not from its end
                    ret_ok_d   = recent_sel;
                    home_cyl_d = cur_cyl_q;
                    step_d     = '0;
                    state_d    = ST_SWEEP_MOVE;
                end
            end
            ST_SWEEP_MOVE:
            begin
                sweep_active_d = 1'b1;
                move_req_d     = 1'b1;
                move_cyl_d     = cur_cyl_q + SWEEP_STRIDE;
                cur_cyl_d      = move_cyl_d;
                state_d        = ST_SWEEP_WAIT;
            end
            ST_SWEEP_WAIT:
                if (seek_done)
                begin
                    if (step_q != 4'(STEPS - 1))
                    begin
                        step_d  = step_q + 4'h1;
                        state_d = ST_SWEEP_MOVE;
                    end
                    else
                        state_d = ST_FINAL_MOVE;
                end
            ST_FINAL_MOVE:
            begin
                if (pend_q)
                begin
                    move_req_d = 1'b1;
                    move_cyl_d = pend_cyl_q;
                    cur_cyl_d  = pend_cyl_q;
                    pend_d     = tag1_seek.valid;
                    by_seek_d  = 1'b1;
                    state_d    = ST_FINAL_WAIT;
                end
                else if (strap_q.return_after && ret_ok_q)
                begin
                    move_req_d = 1'b1;
                    move_cyl_d = home_cyl_q;
                    cur_cyl_d  = home_cyl_q;
                    by_seek_d  = 1'b0;
                    state_d    = ST_FINAL_WAIT;
                end
                else
                begin
                    // heads stay on the last swept cylinder
                    sweep_active_d = 1'b0;
                    state_d        = ST_IDLE;
                end
            end
            ST_FINAL_WAIT:
                if (seek_done)
                begin
                    seek_ack_d     = by_seek_q;
                    by_seek_d      = 1'b0;
                    sweep_active_d = 1'b0;
                    state_d        = ST_IDLE;
                end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_q      <= ST_IDLE;
            step_q       <= '0;
            cur_cyl_q    <= CYL_RESET;
            home_cyl_q   <= CYL_RESET;
            pend_cyl_q   <= CYL_RESET;
            pend_q       <= 1'b0;
            by_seek_q    <= 1'b0;
            ret_ok_q     <= 1'b0;
            move_req     <= 1'b0;
            move_cyl     <= CYL_RESET;
            seek_ack     <= 1'b0;
            sweep_active <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q      <= state_d;
            step_q       <= step_d;
            cur_cyl_q    <= cur_cyl_d;
            home_cyl_q   <= home_cyl_d;
            pend_cyl_q   <= pend_cyl_d;
            pend_q       <= pend_d;
            by_seek_q    <= by_seek_d;
            ret_ok_q     <= ret_ok_d;
            move_req     <= move_req_d;
            move_cyl     <= move_cyl_d;
            seek_ack     <= seek_ack_d;
            sweep_active <= sweep_active_d;
        end
    end

    property p_disable_no_sweep;
        @(posedge mclk) disable iff (!rst_b)
        (strap_q.sweep_disable && state_q == ST_IDLE && !tag1_seek.valid
         && !pend_q) |=> state_q != ST_SWEEP_MOVE;
    endproperty
    a_disable_no_sweep: assert property (p_disable_no_sweep)
        else $error("sweep started while disabled");

    property p_auto_needs_idle;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_q == ST_IDLE && !pend_q && !tag1_seek.valid
         && (drive_busy || selected)) |=> state_q == ST_IDLE;
    endproperty
    a_auto_needs_idle: assert property (p_auto_needs_idle)
        else $error("autonomous sweep while drive busy");

    property p_timer_direct;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_q == ST_IDLE && tag1_seek.valid && seek_only
         && timer_run) |=> state_q == ST_FINAL_WAIT && move_req
         && move_cyl == $past(tag1_seek.cyl);
    endproperty
    a_timer_direct: assert property (p_timer_direct)
        else $error("seek not executed directly");

    property p_seek_starts_sweep;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_q == ST_IDLE && tag1_seek.valid && seek_only
         && !timer_run) |=> state_q == ST_SWEEP_MOVE;
    endproperty
    a_seek_starts_sweep: assert property (p_seek_starts_sweep)
        else $error("expired timer seek did not sweep");

    property p_seek_after_sweep;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_q == ST_FINAL_MOVE && pend_q) |=>
        move_req && move_cyl == $past(pend_cyl_q);
    endproperty
    a_seek_after_sweep: assert property (p_seek_after_sweep)
        else $error("requested cylinder not reached after sweep");

    property p_return_home;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_q == ST_FINAL_MOVE && !pend_q
         && strap_q.return_after && ret_ok_q) |=>
        move_req && move_cyl == $past(home_cyl_q);
    endproperty
    a_return_home: assert property (p_return_home)
        else $error("heads not returned to original cylinder");

    property p_stay_swept;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_q == ST_FINAL_MOVE && !pend_q
         && (!strap_q.return_after || !ret_ok_q)) |=>
        !move_req && state_q == ST_IDLE;
    endproperty
    a_stay_swept: assert property (p_stay_swept)
        else $error("heads moved off swept cylinder");

    property p_sweep_restarts_timer;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && state_q == ST_SWEEP_WAIT && seek_done
         && step_q == 4'(STEPS - 1)) |=> since_swp_q == '0;
    endproperty
    a_sweep_restarts_timer: assert property (p_sweep_restarts_timer)
        else $error("sweep did not restart timer");

    property p_select_clears;
        @(posedge mclk) disable iff (!rst_b)
        (clk_en && selected) |=> since_sel_q == '0;
    endproperty
    a_select_clears: assert property (p_select_clears)
        else $error("select did not clear minute counter");

endmodule

// ---- shared/sweep_pkg.sv ----
/*
 * sweep cycle controller package: timing constants, strap and
 * seek-port carriers, sweep sequencer states.
 * assumes a 50 MHz drive clock.
 */
package sweep_pkg;

    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned MIN_SECONDS    = 60;
    // one minute tick, in clock cycles
    localparam int unsigned MINUTE_CYCLES  = CLK_HZ * MIN_SECONDS;
    localparam int unsigned IDLE_WAIT_MIN  = 12;
    localparam int unsigned SWEEP_PERIOD_MIN = 780;
    localparam int unsigned SWEEP_STEPS    = 8;
    localparam int unsigned CYL_W          = 12;
    localparam int unsigned MIN_W          = 10;
    localparam logic [CYL_W-1:0] CYL_RESET = 12'h000;
    localparam logic [CYL_W-1:0] SWEEP_STRIDE = 12'h0CC;

    typedef struct packed {
        logic sweep_disable;   // connected = high
        logic seek_only;       // connected = high
        logic return_after;    // connected = high
    } straps_t;

    typedef struct packed {
        logic             valid;
        logic [CYL_W-1:0] cyl;
    } seek_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SWEEP_MOVE,
        ST_SWEEP_WAIT,
        ST_FINAL_MOVE,
        ST_FINAL_WAIT
    } sweep_state_t;

endpackage
